// File: logic/tcw_pkg.sv
// Constants and types shared by the tick counter and watchdog block
package tcw_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] TCW_ADDR_TICK_VALUE = 8'h00;
  localparam logic [7:0] TCW_ADDR_TICK_CTRL = 8'h04;
  localparam logic [7:0] TCW_ADDR_DOG_CTRL = 8'h08;
  localparam logic [7:0] TCW_ADDR_CMD = 8'h0c;
  localparam logic [7:0] TCW_ADDR_STATUS = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int TCW_TCTL_RATIO_LSB = 0;
  localparam int TCW_TCTL_DIV_ON = 3;
  localparam int TCW_TCTL_EDGE = 4;
  localparam int TCW_TCTL_SRC = 5;
  localparam int TCW_DCTL_RATIO_LSB = 0;
  localparam int TCW_DCTL_ON = 3;
  localparam int TCW_CMD_DOG_CLEAR = 0;
  localparam int TCW_CMD_SLEEP = 1;
  localparam int TCW_STAT_OVF = 0;
  localparam int TCW_STAT_DOG_LSB = 8;

  // ==========================================================================
  // Values after reset
  localparam logic [5:0] TCW_TICK_CTRL_RST = 6'h3f;
  localparam logic [3:0] TCW_DOG_CTRL_RST = 4'h0;
  localparam logic [7:0] TCW_COUNT_RST = 8'h00;

  // ==========================================================================
  // Cycle counts
  localparam logic [3:0] TCW_INSTR_DIV = 4'h2;
  localparam logic [7:0] TCW_COUNT_MAX = 8'hff;

  // ==========================================================================
  // Operating modes of the core
  typedef enum logic [1:0] {
    TCW_MODE_NORMAL,
    TCW_MODE_GREEN,
    TCW_MODE_IDLE,
    TCW_MODE_SLEEP
  } tcw_mode_t;

endpackage : tcw_pkg

// File: logic/tcw_prescaler.sv
// Eight-bit prescaler dividing a pulse stream by a power of two
`timescale 1ns/1ps
module tcw_prescaler
  import tcw_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire logic i_clr,
  input wire logic [3:0] i_shift,
  // Pulses
  input wire logic i_tick,
  output logic o_tick
);

  logic [7:0] count_ff;
  logic [8:0] full_mask;
  logic [7:0] mask;

  // ==========================================================================
  // Divide ratio mask
  assign full_mask = 9'((9'h001 << i_shift) - 9'h001);
  assign mask = full_mask[7:0];
  assign o_tick = i_tick && ((count_ff & mask) == mask);

  // ==========================================================================
  // Eight-bit divider counter
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= TCW_COUNT_RST;
    end else if (i_clr) begin
      count_ff <= TCW_COUNT_RST;
    end else if (i_tick) begin
      count_ff <= count_ff + 8'h01;
    end
  end

endmodule : tcw_prescaler

// File: logic/tcw_top.sv
// Tick counter and watchdog timer with APB register access
`timescale 1ns/1ps

// Notes on behaviour
// - The tick counter is eight bits and counts the instruction clock or the counter pin.
// - With the instruction clock and no division the counter adds one each instruction cycle.
// - With the pin as source and no division the counter adds one on each chosen edge of the pin.
// - Two separate eight-bit prescalers divide the tick source and the watchdog source.
// - A three-bit field in the tick control register picks the tick divide ratio.
// - A three-bit field in the watchdog control register picks the watchdog divide ratio.
// - Any write of the tick counter value also clears the tick prescaler.
// - The watchdog clear and sleep instructions clear the watchdog prescaler.
// - The watchdog counts the sub-oscillator as sampled on the system clock, and stops when that clock stops.
// - An enabled watchdog timeout in normal, green or idle mode resets the device.
// - Software may turn the watchdog on or off at any time in normal and green mode.
// - Timeout equals the ratio times 256 periods of half the sub-oscillator rate.
// - Divider off passes the tick source through; on gives 1:2 up to 1:256.
// - Watchdog ratio codes 000 to 111 give 1:1 up to 1:128 of the sub-oscillator path.
// - Edge select 0 counts rising and 1 falling; source select 0 is clock and 1 pin.
// - Any reset clears the tick counter, the watchdog and both prescalers.
module tcw_top
  import tcw_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pins and clocks from outside
  input wire logic I_TICK_PIN,
  input wire logic I_SUB_OSC,
  // Core status
  input wire tcw_mode_t I_OP_MODE,
  // Results
  output logic O_DOG_RESET,
  output logic O_TICK_OVF
);

  // ==========================================================================
  // Declarations
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic acc_go;
  logic wr_fire;
  logic addr_hit;
  logic [31:0] nxt_rdata;

  logic [5:0] tick_ctrl_ff;
  logic [3:0] dog_ctrl_ff;
  logic [7:0] tick_counter_value_ff;
  logic [7:0] dog_count_ff;
  logic tick_ovf_ff;
  logic dog_reset_ff;

  logic [3:0] instr_cnt_ff;
  logic instr_tick;

  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_last_ff;
  logic pin_edge;

  logic sub_meta_ff;
  logic sub_sync_ff;
  logic sub_last_ff;
  logic half_ff;
  logic half_tick;

  logic tick_src_pulse;
  logic tick_pre_out;
  logic [3:0] tick_shift;
  logic dog_pre_out;
  logic [3:0] dog_shift;

  logic tick_value_wr;
  logic dog_clear_instruction;
  logic sleep_instruction;
  logic dog_timeout;
  logic dog_fire;
  logic tick_wrap;
  logic ovf_clr;

  logic tick_source_select;
  logic tick_edge_select;
  logic tick_divider_on;
  logic [2:0] tick_ratio_field;
  logic dog_on;
  logic [2:0] dog_ratio_field;

  // ==========================================================================
  // Field views
  assign tick_source_select = tick_ctrl_ff[TCW_TCTL_SRC];
  assign tick_edge_select = tick_ctrl_ff[TCW_TCTL_EDGE];
  assign tick_divider_on = tick_ctrl_ff[TCW_TCTL_DIV_ON];
  assign tick_ratio_field = tick_ctrl_ff[TCW_TCTL_RATIO_LSB +: 3];
  assign dog_on = dog_ctrl_ff[TCW_DCTL_ON];
  assign dog_ratio_field = dog_ctrl_ff[TCW_DCTL_RATIO_LSB +: 3];

  // ==========================================================================
  // APB handshake, one wait state
  assign acc_go = I_PSEL && I_PENABLE && !pready_ff;
  assign wr_fire = I_PSEL && I_PENABLE && I_PWRITE && pready_ff;
  assign addr_hit = (I_PADDR == TCW_ADDR_TICK_VALUE)
    || (I_PADDR == TCW_ADDR_TICK_CTRL)
    || (I_PADDR == TCW_ADDR_DOG_CTRL)
    || (I_PADDR == TCW_ADDR_CMD)
    || (I_PADDR == TCW_ADDR_STATUS);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (acc_go) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !addr_hit;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (I_PADDR)
      TCW_ADDR_TICK_VALUE: begin
        nxt_rdata[7:0] = tick_counter_value_ff;
      end
      TCW_ADDR_TICK_CTRL: begin
        nxt_rdata[5:0] = tick_ctrl_ff;
      end
      TCW_ADDR_DOG_CTRL: begin
        nxt_rdata[3:0] = dog_ctrl_ff;
      end
      TCW_ADDR_STATUS: begin
        nxt_rdata[TCW_STAT_OVF] = tick_ovf_ff;
        nxt_rdata[TCW_STAT_DOG_LSB +: 8] = dog_count_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prdata_ff <= 32'h0000_0000;
    end else if (acc_go && !I_PWRITE) begin
      prdata_ff <= nxt_rdata;
    end else if (acc_go) begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Write decode
  assign tick_value_wr = wr_fire && (I_PADDR == TCW_ADDR_TICK_VALUE);
  assign dog_clear_instruction = wr_fire && (I_PADDR == TCW_ADDR_CMD)
    && I_PWDATA[TCW_CMD_DOG_CLEAR];
  assign sleep_instruction = wr_fire && (I_PADDR == TCW_ADDR_CMD)
    && I_PWDATA[TCW_CMD_SLEEP];
  assign ovf_clr = wr_fire && (I_PADDR == TCW_ADDR_STATUS)
    && I_PWDATA[TCW_STAT_OVF];

  // Tick control register
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_ctrl_ff <= TCW_TICK_CTRL_RST;
    end else if (wr_fire && (I_PADDR == TCW_ADDR_TICK_CTRL)) begin
      tick_ctrl_ff <= I_PWDATA[5:0];
    end
  end

  // Watchdog control register, enable only in normal and green mode
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dog_ctrl_ff <= TCW_DOG_CTRL_RST;
    end else if (wr_fire && (I_PADDR == TCW_ADDR_DOG_CTRL)) begin
      dog_ctrl_ff[TCW_DCTL_RATIO_LSB +: 3] <=
        I_PWDATA[TCW_DCTL_RATIO_LSB +: 3];
      if ((I_OP_MODE == TCW_MODE_NORMAL) || (I_OP_MODE == TCW_MODE_GREEN)) begin
        dog_ctrl_ff[TCW_DCTL_ON] <= I_PWDATA[TCW_DCTL_ON];
      end
    end
  end

  // ==========================================================================
  // Instruction cycle enable
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      instr_cnt_ff <= 4'h0;
    end else if (instr_cnt_ff == TCW_INSTR_DIV - 4'h1) begin
      instr_cnt_ff <= 4'h0;
    end else begin
      instr_cnt_ff <= instr_cnt_ff + 4'h1;
    end
  end

  assign instr_tick = (instr_cnt_ff == TCW_INSTR_DIV - 4'h1);

  // ==========================================================================
  // Counter pin synchroniser and edge detect
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_last_ff <= 1'b0;
    end else begin
      pin_meta_ff <= I_TICK_PIN;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  assign pin_edge = tick_edge_select ? (pin_last_ff && !pin_sync_ff)
                                     : (!pin_last_ff && pin_sync_ff);

  // ==========================================================================
  // Tick source and prescaler
  assign tick_src_pulse = tick_source_select ? pin_edge
                                             : instr_tick;
  assign tick_shift = tick_divider_on ? ({1'b0, tick_ratio_field} + 4'h1)
                                      : 4'h0;

  tcw_prescaler u_tick_pre (
    .i_clk_sys(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_clr(tick_value_wr || dog_fire),
    .i_shift(tick_shift),
    .i_tick(tick_src_pulse),
    .o_tick(tick_pre_out)
  );

  // ==========================================================================
  // Tick counter
  assign tick_wrap = tick_pre_out && (tick_counter_value_ff == TCW_COUNT_MAX);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_counter_value_ff <= TCW_COUNT_RST;
    end else if (dog_fire) begin
      tick_counter_value_ff <= TCW_COUNT_RST;
    end else if (tick_value_wr) begin
      tick_counter_value_ff <= I_PWDATA[7:0];
    end else if (tick_pre_out) begin
      tick_counter_value_ff <= tick_counter_value_ff + 8'h01;
    end
  end

  // Overflow flag, set wins over clear
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_ovf_ff <= 1'b0;
    end else if (tick_wrap && !tick_value_wr && !dog_fire) begin
      tick_ovf_ff <= 1'b1;
    end else if (ovf_clr) begin
      tick_ovf_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Sub-oscillator synchroniser and half-rate enable
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
      sub_last_ff <= 1'b0;
    end else begin
      sub_meta_ff <= I_SUB_OSC;
      sub_sync_ff <= sub_meta_ff;
      sub_last_ff <= sub_sync_ff;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      half_ff <= 1'b0;
    end else if (dog_fire) begin
      half_ff <= 1'b0;
    end else if (sub_sync_ff && !sub_last_ff) begin
      half_ff <= !half_ff;
    end
  end

  assign half_tick = sub_sync_ff && !sub_last_ff && half_ff;

  // ==========================================================================
  // Watchdog prescaler and counter
  assign dog_shift = {1'b0, dog_ratio_field};

  tcw_prescaler u_dog_pre (
    .i_clk_sys(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_clr(dog_clear_instruction || sleep_instruction || dog_fire),
    .i_shift(dog_shift),
    .i_tick(half_tick),
    .o_tick(dog_pre_out)
  );

  assign dog_timeout = dog_pre_out && (dog_count_ff == TCW_COUNT_MAX);
  assign dog_fire = dog_timeout && dog_on
    && (I_OP_MODE != TCW_MODE_SLEEP);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dog_count_ff <= TCW_COUNT_RST;
    end else if (dog_clear_instruction || sleep_instruction || dog_fire) begin
      dog_count_ff <= TCW_COUNT_RST;
    end else if (dog_pre_out) begin
      dog_count_ff <= dog_count_ff + 8'h01;
    end
  end

  // Watchdog reset request pulse
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dog_reset_ff <= 1'b0;
    end else begin
      dog_reset_ff <= dog_fire;
    end
  end

  // ==========================================================================
  // Outputs
  assign O_PRDATA = prdata_ff;
  assign O_PREADY = pready_ff;
  assign O_PSLVERR = pslverr_ff;
  assign O_DOG_RESET = dog_reset_ff;
  assign O_TICK_OVF = tick_ovf_ff;

endmodule : tcw_top

// File: test/tcw_props.sv
// Assertion checker bound to the tick counter and watchdog top
`timescale 1ns/1ps
module tcw_props
  import tcw_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pins, mode and results
  input wire logic I_TICK_PIN,
  input wire logic I_SUB_OSC,
  input wire tcw_mode_t I_OP_MODE,
  input wire logic O_DOG_RESET,
  input wire logic O_TICK_OVF
);
  // ==========
  // Properties
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);
  logic mapped;
  logic clr_req;
  assign mapped = I_PADDR <= 8'h10 && I_PADDR[1:0] == 2'h0;
  assign clr_req = O_PREADY && I_PWRITE && I_PADDR == TCW_ADDR_STATUS
    && I_PWDATA[0];
  ready_wait_a:
    assert property ($rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 O_PREADY)
    else $error("ready timing wrong");
  ready_once_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready too long");
  err_map_a: assert property (O_PREADY |-> O_PSLVERR == !mapped)
    else $error("error flag wrong");
  zero_data_a:
    assert property (O_PREADY && (I_PWRITE || !mapped) |-> O_PRDATA == 32'h0)
    else $error("read data not zero");
  upper_zero_a: assert property (O_PREADY |-> O_PRDATA[31:16] == 16'h0)
    else $error("upper data bits set");
  ovf_read_a:
    assert property (O_PREADY && !I_PWRITE && I_PADDR == TCW_ADDR_STATUS
      |-> O_PRDATA[0] == $past(O_TICK_OVF))
    else $error("status bit differs from flag");
  ovf_clear_a:
    assert property ($fell(O_TICK_OVF)
      |-> $past(clr_req) || O_DOG_RESET || $past(O_DOG_RESET))
    else $error("flag fell without clear");
  dog_pulse_a: assert property (O_DOG_RESET |=> !O_DOG_RESET)
    else $error("reset pulse too long");
  dog_mode_a:
    assert property (O_DOG_RESET |-> $past(I_OP_MODE) != TCW_MODE_SLEEP)
    else $error("reset in sleep mode");
  dog_seen_c: cover property (O_DOG_RESET);
  ovf_seen_c: cover property ($rose(O_TICK_OVF));
  err_seen_c: cover property (O_PSLVERR);
endmodule : tcw_props

bind tcw_top tcw_props tcw_props_inst (
  .I_CLK_SYS, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
  .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_TICK_PIN,
  .I_SUB_OSC, .I_OP_MODE, .O_DOG_RESET, .O_TICK_OVF);

// File: test/testbench.sv
// Self-checking testbench for the tick counter and watchdog block
`timescale 1ns/1ps
module testbench
  import tcw_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pin = 0, sub = 0;
  logic [1:0] sc = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, dog, ovf, se;
  tcw_mode_t mode = TCW_MODE_NORMAL;
  int err_count = 0, n_compared = 0;
  tcw_top tcw_top_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TICK_PIN(pin), .I_SUB_OSC(sub), .I_OP_MODE(mode),
    .O_DOG_RESET(dog), .O_TICK_OVF(ovf));
  // ==========
  // Clocks: sub-oscillator runs free at a quarter of the system clock
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    sc <= sc + 2'h1;
    sub <= sc[1];
  end
  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    check(32'(k), 32'd2);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdc
  task automatic dwait(input int exp);
    int c;
    c = 0;
    while (dog !== 1'b1 && c < 9000) begin
      @(posedge clk);
      c++;
    end
    check(32'(c >= exp - 12 && c <= exp + 24), 32'd1);
  endtask : dwait
  task automatic quiet(input int c);
    int h;
    h = 0;
    repeat (c) begin
      @(posedge clk);
      if (dog !== 1'b0) h++;
    end
    check(32'(h), 32'd0);
  endtask : quiet
  // ==========
  // Scenarios
  task automatic t_reset();
    rdc(TCW_ADDR_TICK_CTRL, 32'h3f);
    rdc(TCW_ADDR_DOG_CTRL, 32'h0);
    rdc(TCW_ADDR_TICK_VALUE, 32'h0);
    apb(1'b1, 8'h14, 32'h1);
    check(32'(se), 32'd1);
  endtask : t_reset
  task automatic t_ratio();
    logic [7:0] a;
    logic [7:0] dl;
    for (int n = 0; n < 9; n++) begin
      apb(1'b1, TCW_ADDR_TICK_CTRL, n == 8 ? 32'h0 : 32'h8 | 32'(n));
      apb(1'b1, TCW_ADDR_TICK_VALUE, 32'h0);
      apb(1'b0, TCW_ADDR_TICK_VALUE, 32'h0);
      a = rd[7:0];
      cyc(n == 8 ? 61 : (4 << (n + 1)) - 3);
      apb(1'b0, TCW_ADDR_TICK_VALUE, 32'h0);
      dl = rd[7:0] - a;
      check({24'h0, dl}, n == 8 ? 32'd32 : 32'd2);
    end
  endtask : t_ratio
  task automatic t_load();
    apb(1'b1, TCW_ADDR_TICK_CTRL, 32'hf);
    apb(1'b1, TCW_ADDR_TICK_VALUE, 32'h0);
    cyc(400);
    apb(1'b1, TCW_ADDR_TICK_VALUE, 32'h55);
    cyc(400);
    rdc(TCW_ADDR_TICK_VALUE, 32'h55);
  endtask : t_load
  task automatic t_ovf();
    apb(1'b1, TCW_ADDR_TICK_CTRL, 32'h0);
    apb(1'b1, TCW_ADDR_TICK_VALUE, 32'hfe);
    cyc(10);
    check(32'(ovf), 32'd1);
    apb(1'b0, TCW_ADDR_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1);
    apb(1'b1, TCW_ADDR_STATUS, 32'h1);
    cyc(1);
    check(32'(ovf), 32'd0);
  endtask : t_ovf
  task automatic t_pin();
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, TCW_ADDR_TICK_CTRL, 32'h20 | 32'(e << 4));
      apb(1'b1, TCW_ADDR_TICK_VALUE, 32'h0);
      pin <= 1'b1;
      cyc(8);
      rdc(TCW_ADDR_TICK_VALUE, 32'(1 - e));
      pin <= 1'b0;
      cyc(8);
      rdc(TCW_ADDR_TICK_VALUE, 32'h1);
    end
  endtask : t_pin
  task automatic t_dog();
    apb(1'b1, TCW_ADDR_TICK_VALUE, 32'h77);
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    apb(1'b1, TCW_ADDR_DOG_CTRL, 32'h8);
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    dwait(2048);
    rdc(TCW_ADDR_TICK_VALUE, 32'h0);
    apb(1'b1, TCW_ADDR_DOG_CTRL, 32'h9);
    apb(1'b1, TCW_ADDR_CMD, 32'h2);
    dwait(4096);
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    cyc(3000);
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    dwait(4096);
    mode <= TCW_MODE_SLEEP;
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    quiet(4600);
    mode <= TCW_MODE_IDLE;
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    dwait(4096);
    apb(1'b1, TCW_ADDR_DOG_CTRL, 32'h0);
    rdc(TCW_ADDR_DOG_CTRL, 32'h8);
    mode <= TCW_MODE_GREEN;
    apb(1'b1, TCW_ADDR_DOG_CTRL, 32'h0);
    apb(1'b1, TCW_ADDR_CMD, 32'h1);
    quiet(4600);
    apb(1'b0, TCW_ADDR_STATUS, 32'h0);
    check(32'(rd[15:8] >= 8'd62 && rd[15:8] <= 8'd65), 32'd1);
  endtask : t_dog
  // ==========
  // Run control
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ratio();
    t_load();
    t_ovf();
    t_pin();
    t_dog();
    tally_and_finish();
  end
  initial begin
    #5_000_000;
    err_count++;
    tally_and_finish();
  end
endmodule : testbench
